/* File: rtl/tmr8_pkg.sv */
// shared constants and types for the 8-bit timer waveform control block
// assumes: a single clk_sys domain and an 8-bit register port
package tmr8_pkg;

  // ----------------------------------------------------------------
  // register port geometry and map
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_CTRL_A = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B = 3'h1;
  localparam logic [2:0] ADDR_COUNT = 3'h2;
  localparam logic [2:0] ADDR_CMP_A = 3'h3;
  localparam logic [2:0] ADDR_CMP_B = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OUTA_HI = 7;
  localparam int OUTA_LO = 6;
  localparam int OUTB_HI = 5;
  localparam int OUTB_LO = 4;
  localparam int WAVE_LO_HI = 1;
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int WAVE_B2_BIT = 3;
  localparam int CLKSEL_HI = 2;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_MA_BIT = 1;
  localparam int FLAG_MB_BIT = 2;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_STEP = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] RSVD_ZERO2 = 2'h0;
  localparam logic [4:0] RSVD_ZERO5 = 5'h00;

  // waveform mode codes
  localparam logic [2:0] WAVE_NORMAL = 3'h0;
  localparam logic [2:0] WAVE_PC_FF = 3'h1;
  localparam logic [2:0] WAVE_CTC = 3'h2;
  localparam logic [2:0] WAVE_FAST_FF = 3'h3;
  localparam logic [2:0] WAVE_PC_CMP = 3'h5;
  localparam logic [2:0] WAVE_FAST_CMP = 3'h7;

  // clock select codes and prescaler taps (log2 of divisor)
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_LOG8 = 3;
  localparam int PRE_LOG64 = 6;
  localparam int PRE_LOG256 = 8;
  localparam int PRE_LOG1024 = 10;

  typedef enum logic [1:0] {
    OUT_OFF = 2'h0,
    OUT_TOGGLE = 2'h1,
    OUT_CLEAR = 2'h2,
    OUT_SET = 2'h3
  } tmr8_outmode_type;

  typedef enum logic [1:0] {
    CLS_PLAIN,
    CLS_FAST,
    CLS_PHASE,
    CLS_RSVD
  } tmr8_class_type;

endpackage

/* File: rtl/tmr8_prescaler.sv */
// clock select and prescaler: turns clk_sys into a timer tick enable
// assumes: ext count pin is asynchronous to clk_sys
`timescale 1ns/1ps
module tmr8_prescaler (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] clockSelect,
  input wire logic extCountPin,
  output logic timerTickEnable
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [tmr8_pkg::PRE_LOG1024-1:0] div;
    logic extMeta;
    logic extSync;
    logic extLast;
  } tmr8_pre_state_type;

  tmr8_pre_state_type state_q;
  tmr8_pre_state_type state_d;

  // divider runs only while a source is chosen; stopping resets phase
  always_comb begin
    state_d = state_q;
    state_d.extMeta = extCountPin;
    state_d.extSync = state_q.extMeta;
    state_d.extLast = state_q.extSync;
    if (clockSelect == tmr8_pkg::CS_STOP) begin
      state_d.div = '0;
    end else begin
      state_d.div = state_q.div + 1'b1;
    end
  end

  // tick pick; edges are seen only after the two-stage synchroniser
  always_comb begin
    unique case (clockSelect)
      tmr8_pkg::CS_STOP: timerTickEnable = 1'b0;
      tmr8_pkg::CS_DIV1: timerTickEnable = 1'b1;
      tmr8_pkg::CS_DIV8:
        timerTickEnable = &state_q.div[tmr8_pkg::PRE_LOG8-1:0];
      tmr8_pkg::CS_DIV64:
        timerTickEnable = &state_q.div[tmr8_pkg::PRE_LOG64-1:0];
      tmr8_pkg::CS_DIV256:
        timerTickEnable = &state_q.div[tmr8_pkg::PRE_LOG256-1:0];
      tmr8_pkg::CS_DIV1024:
        timerTickEnable = &state_q.div[tmr8_pkg::PRE_LOG1024-1:0];
      tmr8_pkg::CS_EXT_FALL:
        timerTickEnable = state_q.extLast & ~state_q.extSync;
      tmr8_pkg::CS_EXT_RISE:
        timerTickEnable = ~state_q.extLast & state_q.extSync;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

/* File: rtl/tmr8_wave_unit.sv */
// one compare-output channel: holds the waveform level and pin override
// assumes: match, wrap and top pulses are already qualified by the tick
`timescale 1ns/1ps
module tmr8_wave_unit (
  input wire logic clk_sys,
  input wire logic reset,
  input wire tmr8_pkg::tmr8_class_type waveClass,
  input wire tmr8_pkg::tmr8_outmode_type outMode,
  input wire logic toggleOk,
  input wire logic match,
  input wire logic forceStrobe,
  input wire logic wrapBottom,
  input wire logic atTop,
  input wire logic countingUp,
  input wire logic cmpIsTop,
  output logic waveOut,
  output logic pinOverride
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic level;
  } tmr8_wave_state_type;

  tmr8_wave_state_type state_q;
  tmr8_wave_state_type state_d;
  logic isSet;
  logic isClear;
  logic pwmToggle;

  assign isSet = (outMode == tmr8_pkg::OUT_SET);
  assign isClear = (outMode == tmr8_pkg::OUT_CLEAR);
  assign pwmToggle = (outMode == tmr8_pkg::OUT_TOGGLE) && toggleOk;

  // level update per mode class; force only counts in plain modes
  always_comb begin
    state_d = state_q;
    unique case (waveClass)
      tmr8_pkg::CLS_PLAIN: begin
        if (match || forceStrobe) begin
          unique case (outMode)
            tmr8_pkg::OUT_OFF: state_d.level = state_q.level;
            tmr8_pkg::OUT_TOGGLE: state_d.level = ~state_q.level;
            tmr8_pkg::OUT_CLEAR: state_d.level = 1'b0;
            tmr8_pkg::OUT_SET: state_d.level = 1'b1;
          endcase
        end
      end
      tmr8_pkg::CLS_FAST: begin
        if (pwmToggle && match) begin
          state_d.level = ~state_q.level;
        end else if (outMode[1]) begin
          // bottom wins; a match at TOP is dropped entirely
          if (wrapBottom) begin
            state_d.level = isClear;
          end else if (match && !cmpIsTop) begin
            state_d.level = isSet;
          end
        end
      end
      tmr8_pkg::CLS_PHASE: begin
        if (pwmToggle && match) begin
          state_d.level = ~state_q.level;
        end else if (outMode[1]) begin
          if (cmpIsTop) begin
            // at TOP take the down-count result for symmetry
            if (atTop) begin
              state_d.level = isClear;
            end
          end else if (match) begin
            state_d.level = countingUp ? isSet : isClear;
          end
        end
      end
      tmr8_pkg::CLS_RSVD: state_d.level = state_q.level;
    endcase
  end

  // pin override: nonzero field, except codes that mean disconnected
  always_comb begin
    pinOverride = (outMode != tmr8_pkg::OUT_OFF);
    if (waveClass == tmr8_pkg::CLS_RSVD) begin
      pinOverride = 1'b0;
    end else if (waveClass != tmr8_pkg::CLS_PLAIN &&
                 outMode == tmr8_pkg::OUT_TOGGLE && !toggleOk) begin
      pinOverride = 1'b0;
    end
  end

  assign waveOut = state_q.level;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

/* File: rtl/tmr8_waveform_ctrl.sv */
// 8-bit timer with two compare-output channels and its control registers
// assumes: an 8-bit register port with read data one cycle after strobe;
// the port pin mux and direction bits live outside this block
`timescale 1ns/1ps
module tmr8_waveform_ctrl (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [tmr8_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tmr8_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [tmr8_pkg::DATA_W-1:0] regRdData,
  input wire logic extCountPin,
  output logic waveOutA,
  output logic waveOutB,
  output logic pinOverrideA,
  output logic pinOverrideB,
  output logic overflowFlag,
  output logic matchFlagA,
  output logic matchFlagB
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    tmr8_pkg::tmr8_outmode_type outModeA;
    tmr8_pkg::tmr8_outmode_type outModeB;
    logic [1:0] waveLo;
    logic waveHi;
    logic [2:0] clockSel;
    logic [7:0] count;
    logic countDown;
    logic [7:0] cmpBufA;
    logic [7:0] cmpBufB;
    logic [7:0] cmpA;
    logic [7:0] cmpB;
    logic ovf;
    logic flagA;
    logic flagB;
    logic blockMatch;
    logic forceA;
    logic forceB;
    logic [7:0] rdData;
  } tmr8_ctrl_state_type;

  tmr8_ctrl_state_type state_q;
  tmr8_ctrl_state_type state_d;

  logic [2:0] waveMode;
  tmr8_pkg::tmr8_class_type waveClass;
  logic [7:0] topValue;
  logic tick;
  logic atTop;
  logic atBottom;
  logic matchA;
  logic matchB;
  logic wrapBottom;
  logic topTurn;
  logic setOvf;
  logic wrCtrlA;
  logic wrCtrlB;
  logic wrCount;
  logic wrCmpA;
  logic wrCmpB;
  logic wrFlags;

  // ----------------------------------------------------------------
  // tick source
  // ----------------------------------------------------------------
  tmr8_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .reset(reset),
    .clockSelect(state_q.clockSel),
    .extCountPin(extCountPin),
    .timerTickEnable(tick)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------

  // mode class and TOP source reserved codes get their own class
  assign waveMode = {state_q.waveHi, state_q.waveLo};
  always_comb begin
    waveClass = tmr8_pkg::CLS_RSVD;
    topValue = tmr8_pkg::CNT_MAX;
    unique case (waveMode)
      tmr8_pkg::WAVE_NORMAL: waveClass = tmr8_pkg::CLS_PLAIN;
      tmr8_pkg::WAVE_CTC: begin
        waveClass = tmr8_pkg::CLS_PLAIN;
        topValue = state_q.cmpA;
      end
      tmr8_pkg::WAVE_FAST_FF: waveClass = tmr8_pkg::CLS_FAST;
      tmr8_pkg::WAVE_FAST_CMP: begin
        waveClass = tmr8_pkg::CLS_FAST;
        topValue = state_q.cmpA;
      end
      tmr8_pkg::WAVE_PC_FF: waveClass = tmr8_pkg::CLS_PHASE;
      tmr8_pkg::WAVE_PC_CMP: begin
        waveClass = tmr8_pkg::CLS_PHASE;
        topValue = state_q.cmpA;
      end
      default: waveClass = tmr8_pkg::CLS_RSVD;
    endcase
  end

  // per-tick events; a count write suppresses the next tick's match
  assign atTop = (state_q.count == topValue);
  assign atBottom = (state_q.count == tmr8_pkg::CNT_BOTTOM);
  assign matchA = tick && !state_q.blockMatch &&
                  (state_q.count == state_q.cmpA);
  assign matchB = tick && !state_q.blockMatch &&
                  (state_q.count == state_q.cmpB);
  assign wrapBottom = tick && atTop && (waveClass == tmr8_pkg::CLS_FAST);
  assign topTurn = tick && atTop && !state_q.countDown &&
                   (waveClass == tmr8_pkg::CLS_PHASE);

  // overflow set point per mode
  always_comb begin
    setOvf = 1'b0;
    unique case (waveMode)
      tmr8_pkg::WAVE_NORMAL, tmr8_pkg::WAVE_CTC, tmr8_pkg::WAVE_FAST_FF:
        setOvf = tick && (state_q.count == tmr8_pkg::CNT_MAX);
      tmr8_pkg::WAVE_PC_FF, tmr8_pkg::WAVE_PC_CMP:
        setOvf = tick && atBottom && state_q.countDown;
      tmr8_pkg::WAVE_FAST_CMP: setOvf = tick && atTop;
      default: setOvf = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  assign wrCtrlA = regWrite && (regAddr == tmr8_pkg::ADDR_CTRL_A);
  assign wrCtrlB = regWrite && (regAddr == tmr8_pkg::ADDR_CTRL_B);
  assign wrCount = regWrite && (regAddr == tmr8_pkg::ADDR_COUNT);
  assign wrCmpA = regWrite && (regAddr == tmr8_pkg::ADDR_CMP_A);
  assign wrCmpB = regWrite && (regAddr == tmr8_pkg::ADDR_CMP_B);
  assign wrFlags = regWrite && (regAddr == tmr8_pkg::ADDR_FLAGS);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.forceA = 1'b0;
    state_d.forceB = 1'b0;
    state_d.rdData = tmr8_pkg::REG_RESET;

    // control registers; reserved bits are simply not stored
    if (wrCtrlA) begin
      state_d.outModeA = tmr8_pkg::tmr8_outmode_type'(
        regWrData[tmr8_pkg::OUTA_HI:tmr8_pkg::OUTA_LO]);
      state_d.outModeB = tmr8_pkg::tmr8_outmode_type'(
        regWrData[tmr8_pkg::OUTB_HI:tmr8_pkg::OUTB_LO]);
      state_d.waveLo = regWrData[tmr8_pkg::WAVE_LO_HI:0];
    end
    if (wrCtrlB) begin
      state_d.waveHi = regWrData[tmr8_pkg::WAVE_B2_BIT];
      state_d.clockSel = regWrData[tmr8_pkg::CLKSEL_HI:0];
      // strobes live one cycle, never stored as a bit
      state_d.forceA = regWrData[tmr8_pkg::FORCE_A_BIT];
      state_d.forceB = regWrData[tmr8_pkg::FORCE_B_BIT];
    end

    // compare buffers; the active copy follows per mode
    if (wrCmpA) begin
      state_d.cmpBufA = regWrData;
    end
    if (wrCmpB) begin
      state_d.cmpBufB = regWrData;
    end
    unique case (waveClass)
      tmr8_pkg::CLS_PLAIN, tmr8_pkg::CLS_RSVD: begin
        state_d.cmpA = state_d.cmpBufA;
        state_d.cmpB = state_d.cmpBufB;
      end
      tmr8_pkg::CLS_FAST: begin
        if (wrapBottom) begin
          state_d.cmpA = state_q.cmpBufA;
          state_d.cmpB = state_q.cmpBufB;
        end
      end
      tmr8_pkg::CLS_PHASE: begin
        if (topTurn) begin
          state_d.cmpA = state_q.cmpBufA;
          state_d.cmpB = state_q.cmpBufB;
        end
      end
    endcase

    // counter; forced compares never reach this path
    if (tick) begin
      state_d.blockMatch = 1'b0;
      unique case (waveClass)
        tmr8_pkg::CLS_PLAIN: begin
          if (waveMode == tmr8_pkg::WAVE_CTC && atTop) begin
            state_d.count = tmr8_pkg::CNT_BOTTOM;
          end else begin
            state_d.count = 8'(state_q.count + tmr8_pkg::CNT_STEP);
          end
        end
        tmr8_pkg::CLS_FAST: begin
          state_d.count = atTop ? tmr8_pkg::CNT_BOTTOM :
                          8'(state_q.count + tmr8_pkg::CNT_STEP);
        end
        tmr8_pkg::CLS_PHASE: begin
          // dual slope: TOP and BOTTOM each last one tick
          if (!state_q.countDown) begin
            if (state_q.count >= topValue) begin
              state_d.countDown = 1'b1;
              state_d.count = atBottom ? tmr8_pkg::CNT_BOTTOM :
                              8'(state_q.count - tmr8_pkg::CNT_STEP);
            end else begin
              state_d.count = 8'(state_q.count + tmr8_pkg::CNT_STEP);
            end
          end else if (atBottom) begin
            state_d.countDown = 1'b0;
            state_d.count = (topValue == tmr8_pkg::CNT_BOTTOM) ?
                            tmr8_pkg::CNT_BOTTOM : tmr8_pkg::CNT_STEP;
          end else begin
            state_d.count = 8'(state_q.count - tmr8_pkg::CNT_STEP);
          end
        end
        tmr8_pkg::CLS_RSVD: state_d.count = state_q.count;
      endcase
    end
    if (waveClass != tmr8_pkg::CLS_PHASE) begin
      state_d.countDown = 1'b0;
    end
    if (wrCount) begin
      state_d.count = regWrData;
      state_d.blockMatch = 1'b1;
    end

    // flags: write one clears, a same-cycle event wins over the clear
    if (wrFlags) begin
      state_d.ovf = state_q.ovf & ~regWrData[tmr8_pkg::FLAG_OVF_BIT];
      state_d.flagA = state_q.flagA & ~regWrData[tmr8_pkg::FLAG_MA_BIT];
      state_d.flagB = state_q.flagB & ~regWrData[tmr8_pkg::FLAG_MB_BIT];
    end
    if (setOvf) begin
      state_d.ovf = 1'b1;
    end
    if (matchA) begin
      state_d.flagA = 1'b1;
    end
    if (matchB) begin
      state_d.flagB = 1'b1;
    end

    // read mux; answer stands only in the cycle after the strobe
    if (regRead) begin
      unique case (regAddr)
        tmr8_pkg::ADDR_CTRL_A:
          state_d.rdData = {state_q.outModeA, state_q.outModeB,
                            tmr8_pkg::RSVD_ZERO2, state_q.waveLo};
        tmr8_pkg::ADDR_CTRL_B:
          state_d.rdData = {tmr8_pkg::RSVD_ZERO2, tmr8_pkg::RSVD_ZERO2,
                            state_q.waveHi, state_q.clockSel};
        tmr8_pkg::ADDR_COUNT: state_d.rdData = state_q.count;
        tmr8_pkg::ADDR_CMP_A: state_d.rdData = state_q.cmpBufA;
        tmr8_pkg::ADDR_CMP_B: state_d.rdData = state_q.cmpBufB;
        tmr8_pkg::ADDR_FLAGS:
          state_d.rdData = {tmr8_pkg::RSVD_ZERO5, state_q.flagB,
                            state_q.flagA, state_q.ovf};
        default: state_d.rdData = tmr8_pkg::REG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // compare output channels
  // ----------------------------------------------------------------

  // channel A may toggle in PWM only with wave mode bit 2 set
  tmr8_wave_unit u_wave_a (
    .clk_sys(clk_sys),
    .reset(reset),
    .waveClass(waveClass),
    .outMode(state_q.outModeA),
    .toggleOk(state_q.waveHi),
    .match(matchA),
    .forceStrobe(state_q.forceA),
    .wrapBottom(wrapBottom),
    .atTop(tick && atTop && (waveClass == tmr8_pkg::CLS_PHASE)),
    .countingUp(!state_q.countDown),
    .cmpIsTop(state_q.cmpA == topValue),
    .waveOut(waveOutA),
    .pinOverride(pinOverrideA)
  );

  // channel B has no PWM toggle; its 01 code is reserved there
  tmr8_wave_unit u_wave_b (
    .clk_sys(clk_sys),
    .reset(reset),
    .waveClass(waveClass),
    .outMode(state_q.outModeB),
    .toggleOk(1'b0),
    .match(matchB),
    .forceStrobe(state_q.forceB),
    .wrapBottom(wrapBottom),
    .atTop(tick && atTop && (waveClass == tmr8_pkg::CLS_PHASE)),
    .countingUp(!state_q.countDown),
    .cmpIsTop(state_q.cmpB == topValue),
    .waveOut(waveOutB),
    .pinOverride(pinOverrideB)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // pin reaches the pad only if software set its direction bit
  assign regRdData = state_q.rdData;
  assign overflowFlag = state_q.ovf;
  assign matchFlagA = state_q.flagA;
  assign matchFlagB = state_q.flagB;

endmodule

/* File: verif/tmr8_waveform_ctrl_sva.sv */
// assertions for the timer waveform control block, bound to its top
// assumes: control fields change only through the register port
`timescale 1ns/1ps
module tmr8_waveform_ctrl_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic waveOutA,
  input wire logic waveOutB,
  input wire logic pinOverrideA,
  input wire logic pinOverrideB,
  input wire logic overflowFlag,
  input wire logic matchFlagA,
  input wire logic matchFlagB
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire wrA = regWrite && regAddr == tmr8_pkg::ADDR_CTRL_A;
  wire wrB = regWrite && regAddr == tmr8_pkg::ADDR_CTRL_B;
  wire wrCnt = regWrite && regAddr == tmr8_pkg::ADDR_COUNT;
  logic [7:0] ctlA_q;
  logic [3:0] ctlB_q;
  // shadow of mode fields, the ports do not show them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctlA_q <= 8'h00;
      ctlB_q <= 4'h0;
    end else if (wrA) begin
      ctlA_q <= regWrData;
    end else if (wrB) begin
      ctlB_q <= regWrData[3:0];
    end
  end
  // force write while the new mode is normal or clear-on-match
  sequence s_forceA;
    wrB && regWrData[7] && !regWrData[3] && !ctlA_q[0];
  endsequence
  sequence s_forceB;
    wrB && regWrData[6] && !regWrData[3] && !ctlA_q[0];
  endsequence
  a_rd_idle_zero: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data nonzero outside read slot");
  a_ctla_rsvd: assert property (
    regRead && regAddr == tmr8_pkg::ADDR_CTRL_A |=> regRdData[3:2] == 2'h0)
    else $error("reserved control bits read nonzero");
  a_force_rdz: assert property (
    regRead && regAddr == tmr8_pkg::ADDR_CTRL_B |=> regRdData[7:6] == 2'h0)
    else $error("force bits read nonzero");
  a_ovr_a_off: assert property (
    wrA && regWrData[7:6] == 2'h0 |=> !pinOverrideA)
    else $error("pin A owned with mode field zero");
  a_ovr_a_on: assert property (
    wrA && regWrData[7] && regWrData[0] |=> pinOverrideA)
    else $error("pin A not owned");
  a_ovr_b_on: assert property (
    wrA && regWrData[5] && regWrData[0] |=> pinOverrideB)
    else $error("pin B not owned");
  a_force_set_a: assert property (
    s_forceA ##0 ctlA_q[7:6] == 2'h3 |-> ##2 waveOutA)
    else $error("forced set on A missing");
  a_force_clr_b: assert property (
    s_forceB ##0 ctlA_q[5:4] == 2'h2 |-> ##2 !waveOutB)
    else $error("forced clear on B missing");
  a_force_noflag: assert property (
    wrB && regWrData[7:6] != 2'h0 && regWrData[2:0] == 3'h0 &&
    ctlB_q[2:0] == 3'h0 && !matchFlagA && !matchFlagB
    |=> (!matchFlagA && !matchFlagB) [*3])
    else $error("forced compare raised a flag");
  a_ovf_at_max: assert property (
    wrCnt && regWrData == 8'hFF && ctlA_q[1:0] == 2'h0 && ctlB_q == 4'h1
    |-> ##[1:4] overflowFlag)
    else $error("no overflow after max");
endmodule
bind tmr8_waveform_ctrl tmr8_waveform_ctrl_chk u_tmr8_waveform_ctrl_chk (
  .clk_sys, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
  .waveOutA, .waveOutB, .pinOverrideA, .pinOverrideB, .overflowFlag,
  .matchFlagA, .matchFlagB);

/* File: verif/tmr8_waveform_ctrl_tb_top.sv */
// self-checking bench for the timer waveform control block
// assumes: bench owns the register port; count pin low except in the edge test
`timescale 1ns/1ps
module tmr8_waveform_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic extCountPin = 1'b0;
  logic [7:0] regRdData, rd;
  logic waveOutA, waveOutB, pinOverrideA, pinOverrideB;
  logic overflowFlag, matchFlagA, matchFlagB, e;
  logic [1:0] m;
  int err_total = 0;
  int checks = 0;
  int ha, hb, k;
  // {ctrl A, ctrl B, owned A, owned B} for PWM and reserved modes
  logic [17:0] ovt [6] = '{{8'h53, 8'h00, 2'h0}, {8'h53, 8'h08, 2'h2},
    {8'h51, 8'h08, 2'h2}, {8'h51, 8'h00, 2'h0}, {8'hF2, 8'h08, 2'h0},
    {8'hF0, 8'h08, 2'h0}};
  // {mode field, wave low bits}: set, clear, toggle twice, set, off
  logic [3:0] fct [6] = '{4'hC, 4'hA, 4'h4, 4'h6, 4'hC, 4'h0};

  always #2 clk_sys = ~clk_sys;

  // pad direction lives outside; only ownership is seen here
  tmr8_waveform_ctrl u_tmr8_waveform_ctrl (.clk_sys, .reset, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData, .extCountPin, .waveOutA,
    .waveOutB, .pinOverrideA, .pinOverrideB, .overflowFlag, .matchFlagA,
    .matchFlagB);

  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdq(input logic [2:0] a);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 rd = regRdData;
  endtask
  // settle for longer than one phase-correct period before measuring
  task automatic pwm(input logic [7:0] ca, cb, a, b, input int n);
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h00);
    wr(tmr8_pkg::ADDR_CTRL_A, 8'h00);
    wr(tmr8_pkg::ADDR_CMP_A, ca);
    wr(tmr8_pkg::ADDR_CMP_B, cb);
    wr(tmr8_pkg::ADDR_CTRL_A, a);
    wr(tmr8_pkg::ADDR_CTRL_B, b); // force bits written zero
    repeat (600) @(posedge clk_sys);
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      ha += waveOutA;
      hb += waveOutB;
    end
  endtask
  task automatic test_done;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    wr(tmr8_pkg::ADDR_CTRL_A, 8'hFF);
    rdq(tmr8_pkg::ADDR_CTRL_A);
    chk(rd, 8'hF3);
    wr(tmr8_pkg::ADDR_CTRL_B, 8'hC8);
    rdq(tmr8_pkg::ADDR_CTRL_B);
    chk(rd, 8'h08);
    rdq(3'h6);
    chk(rd, 8'h00);
    // pin ownership in PWM and reserved modes
    foreach (ovt[i]) begin
      wr(tmr8_pkg::ADDR_CTRL_A, ovt[i][17:10]);
      wr(tmr8_pkg::ADDR_CTRL_B, ovt[i][9:2]);
      #1 chk({pinOverrideA, pinOverrideB}, ovt[i][1:0]);
    end
    // forced compares in normal and clear-on-match modes, clock stopped
    e = 1'b0;
    foreach (fct[i]) begin
      m = fct[i][3:2];
      wr(tmr8_pkg::ADDR_CTRL_A, {m, m, 2'h0, fct[i][1:0]});
      wr(tmr8_pkg::ADDR_CTRL_B, 8'hC0);
      repeat (2) @(posedge clk_sys);
      #1;
      e = (m == 2'h3) ? 1'b1 : (m == 2'h2) ? 1'b0 : (m == 2'h1) ? ~e : e;
      chk({pinOverrideA, pinOverrideB}, {2{m != 2'h0}});
      if (m != 2'h0) chk({waveOutA, waveOutB}, {e, e});
    end
    // a forced match neither clears the count nor raises a flag
    wr(tmr8_pkg::ADDR_CTRL_A, 8'hC2);
    wr(tmr8_pkg::ADDR_COUNT, 8'h55);
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h80);
    rdq(tmr8_pkg::ADDR_COUNT);
    chk(rd, 8'h55);
    chk({matchFlagA, matchFlagB}, 2'h0);
    // force is ignored in fast PWM: clear would drop both outputs
    wr(tmr8_pkg::ADDR_CTRL_A, 8'hA3);
    wr(tmr8_pkg::ADDR_CTRL_B, 8'hC0);
    repeat (3) @(posedge clk_sys);
    #1 chk({waveOutA, waveOutB}, 2'h3);
    // duty per period; compare at top holds B constantly high
    pwm(8'h40, 8'hFF, 8'hA3, 8'h01, 256);
    chk(16'(ha), 16'h0041);
    chk(16'(hb), 16'h0100);
    pwm(8'h40, 8'hFF, 8'hA1, 8'h01, 510);
    chk(16'(ha), 16'h0080);
    chk(16'(hb), 16'h01FE);
    // overflow at max in normal mode, flags cleared while stopped
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h00);
    wr(tmr8_pkg::ADDR_CTRL_A, 8'h00);
    wr(tmr8_pkg::ADDR_COUNT, 8'h00);
    wr(tmr8_pkg::ADDR_FLAGS, 8'h07);
    #1 chk(overflowFlag, 1'b0);
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h01);
    wr(tmr8_pkg::ADDR_COUNT, 8'hFF);
    k = 0;
    while (overflowFlag !== 1'b1 && k < 8) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk(overflowFlag, 1'b1);
    // clear-on-match wraps at compare A and raises only flag A
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h00);
    wr(tmr8_pkg::ADDR_CTRL_A, 8'h02);
    wr(tmr8_pkg::ADDR_CMP_A, 8'h05);
    wr(tmr8_pkg::ADDR_COUNT, 8'h00);
    wr(tmr8_pkg::ADDR_FLAGS, 8'h07);
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h01);
    repeat (6) @(posedge clk_sys);
    rdq(tmr8_pkg::ADDR_COUNT);
    chk(rd, 8'h01);
    chk({matchFlagA, matchFlagB}, 2'h2);
    // count pin rising edges advance the counter, falling ones do not
    wr(tmr8_pkg::ADDR_CTRL_B, 8'h07);
    wr(tmr8_pkg::ADDR_COUNT, 8'h00);
    repeat (3) begin
      extCountPin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      extCountPin <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    rdq(tmr8_pkg::ADDR_COUNT);
    chk(rd, 8'h03);
    test_done();
  end
endmodule
